//--- verilog/serial_unit_pkg.sv
package serial_unit_pkg;

  // timing of the start detector's data delay
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned START_DELAY_MIN_NS = 50;
  localparam int unsigned START_DELAY_MAX_NS = 300;
  localparam int unsigned START_DELAY_CYC =
    (START_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned START_DELAY_MAX_CYC =
    START_DELAY_MAX_NS / CLK_PERIOD_NS;

  // field positions and reset values
  localparam int unsigned SHIFT_MSB = 7;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam logic [3:0] COUNT_MAX = 4'hF;
  localparam logic [3:0] COUNT_STEP = 4'h1;

  typedef enum logic [1:0] {
    WM_OFF,
    WM_THREE,
    WM_TWO,
    WM_TWO_HOLD
  } wire_mode_t;

  typedef struct packed {
    wire_mode_t wire_mode;
    logic external_clock_select;
    logic external_edge_select;
  } serial_cfg_t;

  typedef struct packed {
    logic start_condition_flag;
    logic counter_overflow_flag;
    logic collision;
    logic [3:0] count;
  } serial_status_t;

  typedef struct packed {
    logic do_out;
    logic do_oe_n;
    logic sda_out;
    logic sda_oe_n;
    logic scl_out;
    logic scl_oe_n;
  } pin_drive_t;

  function automatic logic is_two_wire(input wire_mode_t m);
    is_two_wire = (m == WM_TWO) || (m == WM_TWO_HOLD);
  endfunction : is_two_wire

endpackage : serial_unit_pkg

//--- verilog/pin_sync2.sv
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser for the clock and data pins
module pin_sync2 (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // asynchronous levels in, synchronised levels out
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);

  logic [1:0] meta_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 2'h0;
      sync_out <= 2'h0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : pin_sync2

`default_nettype wire

//--- verilog/universal_serial_unit.sv
`timescale 1ns/100ps
`default_nettype none

module universal_serial_unit (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // configuration levels
  input wire serial_unit_pkg::serial_cfg_t cfg,
  input wire logic clock_dir,
  input wire logic data_dir,
  input wire logic data_port_level,
  // software and timer strobes and writes
  input wire logic shift_clock_strobe,
  input wire logic clock_toggle_strobe,
  input wire logic timer_compare_match,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic count_wr,
  input wire logic [3:0] count_wdata,
  input wire logic start_flag_clear,
  input wire logic overflow_flag_clear,
  input wire logic clock_port_wr,
  input wire logic clock_port_wdata,
  // serial pins
  input wire logic serial_data_in,
  input wire logic serial_clock_pin,
  output var serial_unit_pkg::pin_drive_t pins_q,
  // status
  output logic [7:0] shift_register_q,
  output var serial_unit_pkg::serial_status_t status_q
);
  import serial_unit_pkg::*;

  logic [1:0] synced;
  logic scl_s;
  logic di_s;
  logic scl_prev_q;
  logic [START_DELAY_CYC-1:0] sda_dly_q;
  logic dly_out;
  logic dly_prev_q;
  logic [3:0] count_q;
  logic ovf_q;
  logic start_flag_q;
  logic start_hold_q;
  logic collision_q;
  logic samp_q;
  logic dout_q;
  logic clk_port_q;
  logic two_wire;
  logic ext;
  logic strobe_mode;
  logic scl_rise;
  logic scl_fall;
  logic ev;
  logic rising;
  logic sample_ev;
  logic shift_ext;
  logic int_clk;
  logic cnt_inc;
  logic start_ev;
  logic latch_open;
  logic scl_hold;
  logic sda_pull;
  logic scl_pull;

  pin_sync2 u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({serial_clock_pin, serial_data_in}),
    .sync_out(synced)
  );

  assign scl_s = synced[1];
  assign di_s = synced[0];
  assign two_wire = is_two_wire(cfg.wire_mode);
  assign ext = cfg.external_clock_select;

  // clock edge sources
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  // with external clock and the shift strobe, toggle strobe clocks
  assign strobe_mode = ext & shift_clock_strobe;
  assign ev = strobe_mode ? clock_toggle_strobe : (scl_rise | scl_fall);
  assign rising = strobe_mode ? ~clk_port_q : scl_rise;
  // sample on one edge, shift on the other; in two-wire the
  // slave uses select zero so SDA samples on SCL rising
  assign sample_ev = ext & ev & (rising ^ cfg.external_edge_select);
  assign shift_ext = ext & ev & ~(rising ^ cfg.external_edge_select);
  assign int_clk = cfg.external_edge_select ? timer_compare_match
                                            : shift_clock_strobe;
  assign cnt_inc = ext ? ev : int_clk;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_prev_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_s;
    end
  end

  // delayed data copy for start detection
  assign dly_out = sda_dly_q[START_DELAY_CYC-1];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_dly_q <= '1;
      dly_prev_q <= 1'b1;
    end else begin
      sda_dly_q <= {sda_dly_q[START_DELAY_CYC-2:0], di_s};
      dly_prev_q <= dly_out;
    end
  end

  // start is a free-running sampled detector, no software polling
  assign start_ev = two_wire & scl_s & dly_prev_q & ~dly_out;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_flag_q <= 1'b0;
    end else if (start_ev) begin
      start_flag_q <= 1'b1;
    end else if (start_flag_clear) begin
      start_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_hold_q <= 1'b0;
    end else if (!two_wire || (start_flag_clear && !start_ev)) begin
      start_hold_q <= 1'b0;
    end else if (start_flag_q && scl_fall) begin
      start_hold_q <= 1'b1;
    end
  end

  // bit counter; a software write wins over a clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= COUNT_RESET;
    end else if (count_wr) begin
      count_q <= count_wdata;
    end else if (cnt_inc) begin
      count_q <= 4'(count_q + COUNT_STEP);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ovf_q <= 1'b0;
    end else if (cnt_inc && !count_wr && count_q == COUNT_MAX) begin
      ovf_q <= 1'b1;
    end else if (overflow_flag_clear) begin
      ovf_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      samp_q <= 1'b0;
    end else if (sample_ev) begin
      samp_q <= di_s;
    end
  end

  // shift register; a software write wins, no shift that cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_register_q <= SHIFT_RESET;
    end else if (data_wr) begin
      shift_register_q <= data_wdata;
    end else if (shift_ext) begin
      shift_register_q <= {shift_register_q[6:0], samp_q};
    end else if (!ext && int_clk) begin
      shift_register_q <= {shift_register_q[6:0], di_s};
    end
  end

  // output latch open in the first half of an external cycle
  assign latch_open = !ext ||
    ((strobe_mode ? clk_port_q : scl_s) == cfg.external_edge_select);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dout_q <= 1'b0;
    end else if (latch_open) begin
      dout_q <= shift_register_q[SHIFT_MSB];
    end
  end

  // software clock pin: port write or toggle strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_port_q <= 1'b0;
    end else if (clock_port_wr) begin
      clk_port_q <= clock_port_wdata;
    end else if (clock_toggle_strobe) begin
      clk_port_q <= ~clk_port_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      collision_q <= 1'b0;
    end else begin
      collision_q <= two_wire && (shift_register_q[SHIFT_MSB] != di_s);
    end
  end

  // two-wire hold of SCL, only the slave side uses it
  assign scl_hold = two_wire &&
    (start_hold_q || (cfg.wire_mode == WM_TWO_HOLD && ovf_q));
  // open-drain pulls, no filtering or slew shaping
  assign sda_pull = data_dir && !(dout_q && data_port_level);
  assign scl_pull = scl_hold || (clock_dir && !clk_port_q);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pins_q <= '{do_out: 1'b0, do_oe_n: 1'b1, sda_out: 1'b0,
                  sda_oe_n: 1'b1, scl_out: 1'b0, scl_oe_n: 1'b1};
    end else begin
      pins_q.do_out <= dout_q;
      pins_q.do_oe_n <= !(cfg.wire_mode == WM_THREE && data_dir);
      pins_q.sda_out <= 1'b0;
      pins_q.sda_oe_n <= !(two_wire && sda_pull);
      if (two_wire) begin
        pins_q.scl_out <= 1'b0;
        pins_q.scl_oe_n <= !scl_pull;
      end else begin
        pins_q.scl_out <= clk_port_q;
        pins_q.scl_oe_n <= !clock_dir;
      end
    end
  end

  assign status_q = '{start_condition_flag: start_flag_q,
                      counter_overflow_flag: ovf_q,
                      collision: collision_q,
                      count: count_q};

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_wrap;
    cnt_inc && !count_wr && count_q == COUNT_MAX;
  endsequence

  sequence s_hold_pins;
    start_hold_q ##1 (pins_q.scl_oe_n == 1'b0);
  endsequence

  sequence s_internal_run;
    !cfg.external_clock_select ##1 !cfg.external_clock_select;
  endsequence

  AST_OVF_WRAP: assert property (
    s_wrap |=> ovf_q && count_q == COUNT_RESET)
    else $error("counter wrap did not set overflow");

  AST_CNT_STEP: assert property (
    cnt_inc && !count_wr |=> count_q == 4'($past(count_q) + COUNT_STEP))
    else $error("counter did not step by one");

  AST_BOTH_EDGES: assert property (
    ext && !shift_clock_strobe && (scl_rise || scl_fall) && !count_wr
    |=> count_q != $past(count_q))
    else $error("external edge not counted");

  AST_SHIFT_EXT: assert property (
    shift_ext && !data_wr
    |=> shift_register_q == {$past(shift_register_q[6:0]), $past(samp_q)})
    else $error("external shift wrong");

  AST_SAMPLE_RISE: assert property (
    ext && !shift_clock_strobe && !cfg.external_edge_select && scl_rise
    |=> samp_q == $past(di_s))
    else $error("rising edge sample missed");

  AST_SAMPLE_FALL: assert property (
    ext && !shift_clock_strobe && cfg.external_edge_select && scl_fall
    |=> samp_q == $past(di_s))
    else $error("falling edge sample missed");

  AST_STROBE_SHIFT: assert property (
    !ext && !cfg.external_edge_select && shift_clock_strobe && !data_wr
    |=> shift_register_q == {$past(shift_register_q[6:0]), $past(di_s)})
    else $error("strobe shift wrong");

  AST_START_SET: assert property (
    start_ev |=> start_flag_q)
    else $error("start condition not flagged");

  AST_START_MODE: assert property (
    !two_wire && !start_flag_q |=> !start_flag_q)
    else $error("start detected outside two-wire");

  AST_START_HOLD: assert property (
    two_wire && start_flag_q && scl_fall && !start_flag_clear
    |=> s_hold_pins)
    else $error("SCL not held after start");

  AST_START_CLEAR: assert property (
    start_flag_clear && !start_ev |=> !start_flag_q && !start_hold_q)
    else $error("start flag clear failed");

  AST_OVF_HOLD: assert property (
    cfg.wire_mode == WM_TWO_HOLD && ovf_q
    |=> !pins_q.scl_oe_n && !pins_q.scl_out)
    else $error("SCL not held on overflow");

  AST_TOGGLE: assert property (
    clock_toggle_strobe && !clock_port_wr
    |=> clk_port_q != $past(clk_port_q))
    else $error("toggle strobe did not invert clock");

  AST_LATCH_INT: assert property (
    s_internal_run |-> dout_q == $past(shift_register_q[SHIFT_MSB]))
    else $error("output latch not transparent");

  AST_THREE_DO: assert property (
    cfg.wire_mode == WM_THREE && data_dir
    |=> pins_q.do_out == $past(dout_q) && !pins_q.do_oe_n)
    else $error("data out not driven in three-wire");

  AST_START_DELAY: assert property (
    $fell(di_s) |-> ##5 $fell(dly_out))
    else $error("SDA delay not as set");

  AST_DELAY_RANGE: assert property (
    START_DELAY_CYC <= START_DELAY_MAX_CYC)
    else $error("SDA delay above limit");

endmodule : universal_serial_unit

`default_nettype wire

//--- tb/serial_peer.sv
`timescale 1ns/100ps
`default_nettype none

module serial_peer (
  // lines seen by the peer
  input wire logic scl_line,
  input wire logic do_line,
  // lines driven by the peer, high means released
  output logic scl_drv,
  output logic sd_drv
);
  localparam int HALF = 80;
  logic [7:0] rx_q;
  int expired;
  logic waited;

  initial begin
    scl_drv = 1'b0;
    sd_drv = 1'b1;
    rx_q = 8'h00;
    expired = 0;
    waited = 1'b0;
  end

  // data set half a clock before the sampling edge
  task automatic clk_bit(input logic b);
    int n;
    sd_drv = b;
    #HALF;
    scl_drv = 1'b1; // clock made by the peer
    n = 0;
    while (scl_line !== 1'b1 && n < 200) begin // stretch
      #10;
      n++;
    end
    waited = (n > 0);
    if (scl_line !== 1'b1)
      expired++;
    rx_q = {rx_q[6:0], do_line};
    #HALF;
    scl_drv = 1'b0;
  endtask : clk_bit

  task automatic start_cond();
    scl_drv = 1'b1;
    sd_drv = 1'b1;
    #HALF;
    sd_drv = 1'b0; // data pulled low while clock high
    #HALF;
    scl_drv = 1'b0;
    #HALF;
  endtask : start_cond
endmodule : serial_peer

`default_nettype wire

//--- tb/universal_serial_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none

module universal_serial_unit_tb;
  import serial_unit_pkg::*;
  localparam logic [7:0] SHF = 8'h80, TOG = 8'h40, TIM = 8'h20, DWR = 8'h10;
  localparam logic [7:0] CWR = 8'h08, SCLR = 8'h04, OCLR = 8'h02;
  localparam logic [7:0] PWR = 8'h01;
  logic clk, resetn, clock_dir, data_dir, data_port_level;
  logic shift_clock_strobe, clock_toggle_strobe, timer_compare_match;
  logic data_wr, count_wr, start_flag_clear, overflow_flag_clear;
  logic clock_port_wr, clock_port_wdata;
  logic [7:0] data_wdata;
  logic [3:0] count_wdata;
  serial_cfg_t cfg;
  pin_drive_t pins_q;
  logic [7:0] shift_register_q;
  serial_status_t status_q;
  logic scl_drv, sd_drv, scl_line, sda_line;
  int fails, checks_done;

  // wired-and lines with pull-ups
  assign scl_line = scl_drv & (pins_q.scl_oe_n | pins_q.scl_out);
  assign sda_line = sd_drv & (pins_q.sda_oe_n | pins_q.sda_out);

  universal_serial_unit universal_serial_unit_inst (
    .clk(clk), .resetn(resetn), .cfg(cfg), .clock_dir(clock_dir),
    .data_dir(data_dir), .data_port_level(data_port_level),
    .shift_clock_strobe(shift_clock_strobe),
    .clock_toggle_strobe(clock_toggle_strobe),
    .timer_compare_match(timer_compare_match), .data_wr(data_wr),
    .data_wdata(data_wdata), .count_wr(count_wr),
    .count_wdata(count_wdata), .start_flag_clear(start_flag_clear),
    .overflow_flag_clear(overflow_flag_clear),
    .clock_port_wr(clock_port_wr), .clock_port_wdata(clock_port_wdata),
    .serial_data_in(sda_line), .serial_clock_pin(scl_line),
    .pins_q(pins_q), .shift_register_q(shift_register_q),
    .status_q(status_q)
  );

  serial_peer serial_peer_inst (
    .scl_line(scl_line), .do_line(pins_q.do_out),
    .scl_drv(scl_drv), .sd_drv(sd_drv)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic drive(logic [7:0] s);
    @(negedge clk);
    {shift_clock_strobe, clock_toggle_strobe, timer_compare_match, data_wr,
     count_wr, start_flag_clear, overflow_flag_clear, clock_port_wr} = s;
  endtask : drive

  task automatic idle(int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic load(logic [7:0] d, logic [3:0] c);
    data_wdata = d;
    count_wdata = c;
    drive(DWR | CWR | SCLR | OCLR);
    drive(8'h00);
    idle(1);
  endtask : load

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic t_reset();
    check("shift", shift_register_q, 8'h00);
    check("status", {1'b0, status_q}, 8'h00);
    check("oe_n", {5'h0, pins_q.do_oe_n, pins_q.sda_oe_n,
      pins_q.scl_oe_n}, 8'h07);
  endtask : t_reset

  task automatic t_strobe();
    cfg = '{WM_OFF, 1'b0, 1'b0};
    load(8'hA5, 4'hF);
    drive(SHF);
    drive(8'h00);
    idle(1);
    check("shift", shift_register_q, 8'h4B);
    check("count", {4'h0, status_q.count}, 8'h00);
    check("ovf", {7'h0, status_q.counter_overflow_flag}, 8'h01);
    data_wdata = 8'h5A;
    drive(DWR | SHF | OCLR);
    drive(8'h00);
    idle(1);
    check("wr wins", shift_register_q, 8'h5A);
    check("ovf clr", {7'h0, status_q.counter_overflow_flag}, 8'h00);
  endtask : t_strobe

  task automatic t_spi();
    logic [7:0] tx;
    tx = 8'hC5;
    cfg = '{WM_THREE, 1'b1, 1'b0};
    data_dir = 1'b1;
    load(8'h3C, 4'h0);
    for (int i = 7; i >= 0; i--)
      serial_peer_inst.clk_bit(tx[i]);
    idle(6);
    check("rx", shift_register_q, 8'hC5);
    check("peer rx", serial_peer_inst.rx_q, 8'h3C);
    check("ovf", {7'h0, status_q.counter_overflow_flag}, 8'h01);
    check("count", {4'h0, status_q.count}, 8'h00);
  endtask : t_spi

  task automatic t_edge();
    for (int s = 0; s < 2; s++) begin
      cfg = '{WM_THREE, 1'b1, s[0]};
      load(8'h81, 4'h0);
      serial_peer_inst.scl_drv = 1'b1;
      idle(6);
      check("edge", {1'b0, shift_register_q[7:1]},
        (s == 1) ? 8'h01 : 8'h40);
      check("count", {4'h0, status_q.count}, 8'h01);
      serial_peer_inst.scl_drv = 1'b0;
      idle(6);
    end
  endtask : t_edge

  task automatic t_soft();
    cfg = '{WM_THREE, 1'b0, 1'b0};
    clock_dir = 1'b1;
    clock_port_wdata = 1'b0;
    load(8'h00, 4'h0);
    drive(PWR);
    drive(TOG);
    drive(8'h00);
    idle(2);
    check("pin", {6'h0, pins_q.scl_out, pins_q.scl_oe_n}, 8'h02);
    for (int i = 0; i < 8; i++) begin
      drive(TOG);
      drive(TOG | SHF);
    end
    drive(8'h00);
    idle(2);
    check("fast", shift_register_q, 8'hFF);
    check("fast cnt", {4'h0, status_q.count}, 8'h08);
    check("pin", {6'h0, pins_q.scl_out, pins_q.scl_oe_n}, 8'h02);
    cfg = '{WM_THREE, 1'b0, 1'b1};
    drive(TIM);
    drive(8'h00);
    idle(1);
    check("timer", {4'h0, status_q.count}, 8'h09);
    cfg = '{WM_THREE, 1'b1, 1'b0};
    load(8'h0F, 4'h0);
    drive(PWR);
    repeat (16) drive(TOG | SHF);
    drive(8'h00);
    idle(1);
    check("strobe clk", shift_register_q, 8'hFF);
    check("strobe ovf", {3'h0, status_q.counter_overflow_flag,
      status_q.count}, 8'h10);
    clock_dir = 1'b0;
  endtask : t_soft

  task automatic t_two();
    logic [7:0] adr;
    adr = 8'hA4;
    cfg = '{WM_THREE, 1'b0, 1'b0};
    data_dir = 1'b0;
    load(8'h00, 4'h0);
    serial_peer_inst.start_cond();
    idle(12);
    check("no start", {7'h0, status_q.start_condition_flag}, 8'h00);
    serial_peer_inst.scl_drv = 1'b1;
    serial_peer_inst.sd_drv = 1'b1;
    cfg = '{WM_TWO_HOLD, 1'b1, 1'b0};
    load(8'h00, 4'h0);
    serial_peer_inst.start_cond();
    check("start", {7'h0, status_q.start_condition_flag}, 8'h01);
    check("st hold", {7'h0, pins_q.scl_oe_n}, 8'h00);
    load(8'h00, 4'h0);
    idle(3);
    check("st free", {7'h0, pins_q.scl_oe_n}, 8'h01);
    for (int i = 7; i >= 0; i--)
      serial_peer_inst.clk_bit(adr[i]);
    idle(6);
    check("addr", shift_register_q, 8'hA4);
    check("collide", {7'h0, status_q.collision}, 8'h01);
    check("ov hold", {6'h0, status_q.counter_overflow_flag,
      pins_q.scl_oe_n}, 8'h02);
    count_wdata = 4'hE;
    drive(CWR);
    drive(8'h00);
    fork
      serial_peer_inst.clk_bit(1'b1);
      begin
        idle(20);
        drive(OCLR);
        drive(8'h00);
      end
    join
    idle(6);
    check("stretch", {7'h0, serial_peer_inst.waited}, 8'h01);
    check("ack ovf", {3'h0, status_q.counter_overflow_flag,
      status_q.count}, 8'h10);
    cfg.wire_mode = WM_TWO;
    idle(3);
    check("no ov hold", {7'h0, pins_q.scl_oe_n}, 8'h01);
    cfg.wire_mode = WM_TWO_HOLD;
    drive(OCLR);
    drive(8'h00);
    idle(3);
    check("ov free", {7'h0, pins_q.scl_oe_n}, 8'h01);
    data_dir = 1'b1;
    idle(3);
    check("sda drv", {6'h0, pins_q.sda_out, pins_q.sda_oe_n},
      8'h00);
    data_dir = 1'b0;
    check("no hang", 8'(serial_peer_inst.expired), 8'h00);
  endtask : t_two

  // scenarios need well under 20 us; give up after 200 us
  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  initial begin
    fails = 0;
    checks_done = 0;
    resetn = 1'b0;
    cfg = '{WM_OFF, 1'b0, 1'b0};
    clock_dir = 1'b0;
    data_dir = 1'b0;
    data_port_level = 1'b1;
    {shift_clock_strobe, clock_toggle_strobe, timer_compare_match, data_wr,
     count_wr, start_flag_clear, overflow_flag_clear, clock_port_wr} = 8'h00;
    data_wdata = 8'h00;
    count_wdata = 4'h0;
    clock_port_wdata = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    idle(2);
    t_reset();
    t_strobe();
    t_spi();
    t_edge();
    t_soft();
    t_two();
    wrap_up();
  end
endmodule : universal_serial_unit_tb

`default_nettype wire
